// [rtd_params.svh]
// Offsets, field positions, reset values and timing counts of the clock word registers.
// Included by the register module and the bench; holds definitions only.
`ifndef RTD_PARAMS_SVH
`define RTD_PARAMS_SVH

// Register offsets on the register port
`define RTD_ADDR_TIME 6'h14
`define RTD_ADDR_TIME_ALARM 6'h15
`define RTD_ADDR_DAY 6'h16
`define RTD_ADDR_DAY_ALARM 6'h17

// Field positions
`define RTD_SEC_MSB 16
`define RTD_CAL_LSB 17
`define RTD_CAL_MSB 21
`define RTD_MODE_LSB 22
`define RTD_MODE_MSB 23
`define RTD_SPARE_LSB 17
`define RTD_SPARE_MSB 22
`define RTD_DISABLE_BIT 23
`define RTD_DAY_MSB 14

// Reset values
`define RTD_TIME_RST 24'h00_0000
`define RTD_SEC_ALARM_RST 17'h1_ffff
`define RTD_SPARE_RST 6'h00
`define RTD_DAY_RST 15'h0000
`define RTD_DAY_ALARM_RST 15'h7fff

// Seconds in one day less one (86399); the last count before rollover
`define RTD_SEC_LAST 17'h1_517f

`endif

// [rtd_pkg.sv]
// Types shared by the clock word registers.
// Assumes a tool that takes packed structs; needs no header of its own.
`default_nettype none
package rtd_pkg;
    typedef struct packed {
        logic [1:0] cal_mode;
        logic [4:0] cal_count;
        logic [16:0] seconds;
    } rtd_time_t;

    typedef struct packed {
        logic clock_disable;
        logic [5:0] spare;
        logic [16:0] seconds_alarm;
    } rtd_alarm_t;

    typedef struct packed {
        logic [5:0] addr;
        logic wr_en;
        logic rd_en;
        logic [23:0] wr_data;
    } rtd_req_t;
endpackage
`default_nettype wire

// [rtd_regs.sv]
// Real time clock words: time of day, time alarm, day counter, day alarm.
// Assumes the chip's serial front end delivers decoded word accesses on clk_sys,
// and a once-per-second tick arriving asynchronously on a pin.
`timescale 1ns/1ps
`default_nettype none
`include "rtd_params.svh"

// Notes on behaviour
// - Time word: seconds 0-16, calibration count 17-21, mode 22-23, reset zero.
// - Alarm word: seconds alarm resets all ones, spares zero, bit 23 disables clock.
// - Day counter bits 0-14 read/write reset zero; bits 15-23 read zero.
// - Day alarm bits 0-14 read/write reset ones; bits 15-23 read zero.
module rtd_regs
    import rtd_pkg::*;
(
    // Clock and clock power-on reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port
    input wire rtd_req_t reg_req,
    output logic [23:0] reg_rd_data,
    output logic reg_rd_valid,
    // Second tick from the oscillator divider
    input wire logic second_tick_pin,
    // Status
    output logic alarm_event,
    output logic clock_running
);
    rtd_time_t time_word;
    rtd_time_t next_time_word;
    rtd_alarm_t alarm_word;
    rtd_alarm_t next_alarm_word;
    logic [14:0] day_count;
    logic [14:0] next_day_count;
    logic [14:0] date_alarm;
    logic [14:0] next_date_alarm;
    logic [23:0] next_rd_data;
    logic next_rd_valid;
    logic tick_meta;
    logic tick_sync;
    logic tick_prev;
    logic tick;
    logic match;
    logic match_q;
    logic next_alarm_event;
    logic next_clock_running;

    // Address decode, shared by the write and read paths
    function automatic logic hit(input logic [5:0] a, input logic [5:0] target);
        hit = (a == target);
    endfunction

    // Two-stage tick synchroniser; edge taken after the second stage only
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tick_meta <= 1'b0;
            tick_sync <= 1'b0;
            tick_prev <= 1'b0;
        end
        else
        begin
            tick_meta <= second_tick_pin;
            tick_sync <= tick_meta;
            tick_prev <= tick_sync;
        end
    end

    assign tick = tick_sync & ~tick_prev;
    assign match = (time_word.seconds == alarm_word.seconds_alarm) && (day_count == date_alarm);

    // Next state of the words; a host write wins over a tick in the same cycle
    // Day count wraps silently at 15 bits; calibration fields are stored only,
    // so any rate trimming has to live in the oscillator divider
    always_comb
    begin
        next_time_word = time_word;
        next_alarm_word = alarm_word;
        next_day_count = day_count;
        next_date_alarm = date_alarm;
        if (tick && !alarm_word.clock_disable)
        begin
            if (time_word.seconds == `RTD_SEC_LAST)
            begin
                next_time_word.seconds = 17'h0_0000;
                next_day_count = day_count + 15'h0001;
            end
            else
            begin
                next_time_word.seconds = time_word.seconds + 17'h0_0001;
            end
        end
        if (reg_req.wr_en)
        begin
            if (hit(reg_req.addr, `RTD_ADDR_TIME))
                next_time_word = rtd_time_t'(reg_req.wr_data);
            if (hit(reg_req.addr, `RTD_ADDR_TIME_ALARM))
                next_alarm_word = rtd_alarm_t'(reg_req.wr_data);
            if (hit(reg_req.addr, `RTD_ADDR_DAY))
                next_day_count = reg_req.wr_data[`RTD_DAY_MSB:0];
            if (hit(reg_req.addr, `RTD_ADDR_DAY_ALARM))
                next_date_alarm = reg_req.wr_data[`RTD_DAY_MSB:0];
        end
    end

    // Word registers; reset is the clock's own power-on reset
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            time_word <= `RTD_TIME_RST;
            alarm_word <= {1'b0, `RTD_SPARE_RST, `RTD_SEC_ALARM_RST};
            day_count <= `RTD_DAY_RST;
            date_alarm <= `RTD_DAY_ALARM_RST;
        end
        else
        begin
            time_word <= next_time_word;
            alarm_word <= next_alarm_word;
            day_count <= next_day_count;
            date_alarm <= next_date_alarm;
        end
    end

    // Read mux; unused upper day bits and unmapped offsets read zero
    always_comb
    begin
        next_rd_valid = reg_req.rd_en;
        next_rd_data = reg_rd_data;
        if (reg_req.rd_en)
        begin
            next_rd_data = 24'h00_0000;
            if (hit(reg_req.addr, `RTD_ADDR_TIME))
                next_rd_data = time_word;
            if (hit(reg_req.addr, `RTD_ADDR_TIME_ALARM))
                next_rd_data = alarm_word;
            if (hit(reg_req.addr, `RTD_ADDR_DAY))
                next_rd_data = {9'h000, day_count};
            if (hit(reg_req.addr, `RTD_ADDR_DAY_ALARM))
                next_rd_data = {9'h000, date_alarm};
        end
    end

    // Alarm fires once on entering a match, not every cycle it holds;
    // running flag follows the disable bit as it is being stored
    always_comb
    begin
        next_alarm_event = match & ~match_q;
        next_clock_running = ~next_alarm_word.clock_disable;
    end

    // Read data, alarm edge and running flag registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rd_data <= 24'h00_0000;
            reg_rd_valid <= 1'b0;
            match_q <= 1'b1;
            alarm_event <= 1'b0;
            clock_running <= 1'b0;
        end
        else
        begin
            reg_rd_data <= next_rd_data;
            reg_rd_valid <= next_rd_valid;
            match_q <= match;
            alarm_event <= next_alarm_event;
            clock_running <= next_clock_running;
        end
    end

    // Checks
    a_time_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_req.wr_en && reg_req.addr == `RTD_ADDR_TIME |=> time_word == $past(reg_req.wr_data))
        else $error("time word write not stored");
    a_alarm_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_req.wr_en && reg_req.addr == `RTD_ADDR_TIME_ALARM |=> alarm_word == $past(reg_req.wr_data))
        else $error("alarm word write not stored");
    a_day_read_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_req.rd_en && reg_req.addr == `RTD_ADDR_DAY |=> reg_rd_valid && reg_rd_data[23:15] == 9'h000
        && reg_rd_data[14:0] == $past(day_count))
        else $error("day read wrong or upper bits set");
    a_day_alarm_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_req.rd_en && reg_req.addr == `RTD_ADDR_DAY_ALARM |=> reg_rd_data == {9'h000, $past(date_alarm)})
        else $error("day alarm read wrong");
    a_disable_freeze: assert property (@(posedge clk_sys) disable iff (!arst_n)
        alarm_word.clock_disable && !reg_req.wr_en |=> $stable(time_word.seconds) && $stable(day_count))
        else $error("counters moved while disabled");
    a_tick_advance: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tick && !alarm_word.clock_disable && !reg_req.wr_en && time_word.seconds != `RTD_SEC_LAST
        |=> time_word.seconds == $past(time_word.seconds) + 17'h0_0001)
        else $error("seconds did not advance on tick");
    a_day_rollover: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tick && !alarm_word.clock_disable && !reg_req.wr_en && time_word.seconds == `RTD_SEC_LAST
        |=> time_word.seconds == 17'h0_0000 && day_count == $past(day_count) + 15'h0001)
        else $error("day rollover wrong");
    a_alarm_cause: assert property (@(posedge clk_sys) disable iff (!arst_n)
        alarm_event |-> $past(match) && !$past(match_q))
        else $error("alarm event without new match");
    a_alarm_single: assert property (@(posedge clk_sys) disable iff (!arst_n)
        alarm_event |=> !alarm_event)
        else $error("alarm event longer than one cycle");
    a_time_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_req.rd_en && reg_req.addr == `RTD_ADDR_TIME |=> reg_rd_valid && reg_rd_data == $past(time_word))
        else $error("time word read wrong");
    a_time_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !tick && !reg_req.wr_en |=> $stable(time_word))
        else $error("time word changed without tick or write");
    a_alarm_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_req.rd_en && reg_req.addr == `RTD_ADDR_TIME_ALARM |=> reg_rd_valid && reg_rd_data == $past(alarm_word))
        else $error("alarm word read wrong");
    a_running_flag: assert property (@(posedge clk_sys) disable iff (!arst_n)
        $past(arst_n) |-> clock_running == !alarm_word.clock_disable)
        else $error("running flag disagrees with disable bit");
    a_day_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_req.wr_en && reg_req.addr == `RTD_ADDR_DAY |=> day_count == $past(reg_req.wr_data[`RTD_DAY_MSB:0]))
        else $error("day write not stored");
    a_read_idle: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !reg_req.rd_en |=> !reg_rd_valid)
        else $error("read valid without read strobe");
    a_date_alarm_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
        reg_req.wr_en && reg_req.addr == `RTD_ADDR_DAY_ALARM |=> date_alarm == $past(reg_req.wr_data[`RTD_DAY_MSB:0]))
        else $error("day alarm write not stored");
endmodule
`default_nettype wire

// [rtd_regs_tb_top.sv]
// Self-checking bench for the clock word registers.
// Assumes rtd_pkg, rtd_params.svh and the tick source model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "rtd_params.svh"
module rtd_regs_tb_top
    import rtd_pkg::*;
();
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    rtd_req_t reg_req = '0;
    logic [23:0] reg_rd_data;
    logic reg_rd_valid;
    logic second_tick_pin;
    logic alarm_event;
    logic clock_running;
    int n_errors = 0;
    int num_checks = 0;
    int n_alarms = 0;

    always #2.5 clk_sys = ~clk_sys;

    rtd_regs i_rtd_regs (.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(reg_req), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .second_tick_pin(second_tick_pin), .alarm_event(alarm_event),
        .clock_running(clock_running));
    rtd_tick_src i_rtd_tick_src (.clk_sys(clk_sys), .second_tick_pin(second_tick_pin));

    // Count alarm pulses; a pulse that sticks would count many times
    always @(posedge clk_sys)
    begin
        if (alarm_event === 1'b1)
            n_alarms++;
    end

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, seen);
            n_errors++;
        end
    endtask

    // Word write: one-cycle strobe, entered and left at a rising edge
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        reg_req <= {a, 1'b1, 1'b0, d};
        @(posedge clk_sys);
        reg_req.wr_en <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Word read: valid stands for the one cycle after the strobe is taken,
    // so it is looked at just past the taking edge, not an edge later
    task automatic rd(input logic [5:0] a, input logic [23:0] exp);
        reg_req <= {a, 1'b0, 1'b1, 24'h00_0000};
        @(posedge clk_sys);
        reg_req.rd_en <= 1'b0;
        #1;
        chk("rd_valid", {23'h00_0000, reg_rd_valid}, 24'h00_0001);
        chk("rd_data", reg_rd_data, exp);
        @(posedge clk_sys);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog, far beyond the hundred or so cycles the tests need
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        n_errors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // Reset values, then an unmapped offset that must ignore writes
        rd(`RTD_ADDR_TIME, 24'h00_0000);
        rd(`RTD_ADDR_TIME_ALARM, 24'h01_ffff);
        rd(`RTD_ADDR_DAY, 24'h00_0000);
        rd(`RTD_ADDR_DAY_ALARM, 24'h00_7fff);
        wr(6'h18, 24'hff_ffff);
        rd(6'h18, 24'h00_0000);
        // All ones; seconds kept one short of the alarm so nothing fires
        wr(`RTD_ADDR_TIME, 24'hff_fffe);
        wr(`RTD_ADDR_TIME_ALARM, 24'hff_ffff);
        wr(`RTD_ADDR_DAY, 24'hff_ffff);
        wr(`RTD_ADDR_DAY_ALARM, 24'hff_ffff);
        rd(`RTD_ADDR_TIME, 24'hff_fffe);
        rd(`RTD_ADDR_TIME_ALARM, 24'hff_ffff);
        rd(`RTD_ADDR_DAY, 24'h00_7fff);
        rd(`RTD_ADDR_DAY_ALARM, 24'h00_7fff);
        chk("clock_running", {23'h00_0000, clock_running}, 24'h00_0000);
        // A tick while disabled is lost
        i_rtd_tick_src.pulse();
        rd(`RTD_ADDR_TIME, 24'hff_fffe);
        // Enable, park at the last second of the last day, tick into both wraps
        wr(`RTD_ADDR_TIME_ALARM, 24'h00_0001);
        wr(`RTD_ADDR_TIME, 24'hc3_517f);
        chk("clock_running", {23'h00_0000, clock_running}, 24'h00_0001);
        i_rtd_tick_src.pulse();
        rd(`RTD_ADDR_TIME, 24'hc2_0000);
        rd(`RTD_ADDR_DAY, 24'h00_0000);
        // Day alarm to zero; the next tick matches both alarms
        wr(`RTD_ADDR_DAY_ALARM, 24'h00_0000);
        chk("alarm_count", n_alarms[23:0], 24'h00_0000);
        i_rtd_tick_src.pulse();
        chk("alarm_count", n_alarms[23:0], 24'h00_0001);
        // Power-on reset again in mid-run: every word back to reset value, no alarm
        arst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rd(`RTD_ADDR_TIME, 24'h00_0000);
        rd(`RTD_ADDR_TIME_ALARM, 24'h01_ffff);
        rd(`RTD_ADDR_DAY, 24'h00_0000);
        rd(`RTD_ADDR_DAY_ALARM, 24'h00_7fff);
        chk("clock_running", {23'h00_0000, clock_running}, 24'h00_0001);
        chk("alarm_count", n_alarms[23:0], 24'h00_0001);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [rtd_tick_src.sv]
// Second tick source standing in for the oscillator divider.
// Assumes clk_sys from the bench; ticks are spaced well past the sync depth.
`timescale 1ns/1ps
`default_nettype none
module rtd_tick_src (
    // Clock
    input wire logic clk_sys,
    // Tick pin
    output logic second_tick_pin
);
    initial second_tick_pin = 1'b0;
    // One tick, high and low long enough that the two-flop sync sees it once
    task automatic pulse();
        @(posedge clk_sys);
        second_tick_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
        second_tick_pin <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire
